// ==== spm_pkg.sv ====
/*
 * Shared constants and types for the soft power event status block:
 * register offsets, bit positions, reset values, hold timing and carriers.
 * Assumes a 40 MHz system clock and an 8-bit register port.
 */
`default_nettype none
package spm_pkg;
    // Clock and button hold timing
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned HOLD_TIME_S = 4;
    localparam int unsigned HOLD_CYCLES = HOLD_TIME_S * CLK_HZ + 1; // Strictly more than

    // Register port widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [7:0] STATUS_ADDR  = 8'h79;
    localparam logic [7:0] ENABLE_ADDR  = 8'h7b;
    localparam logic [7:0] MASK_ADDR    = 8'h7d;
    localparam logic [7:0] CONTROL_ADDR = 8'h7e;

    // Status, enable and mask bit positions
    localparam int unsigned BIT_BUTTON   = 0;
    localparam int unsigned BIT_ALARM    = 2;
    localparam int unsigned BIT_OVERRIDE = 3;
    localparam int unsigned BIT_WAKE     = 7;

    // Control bit positions
    localparam int unsigned CTL_SLEEP = 0;
    localparam int unsigned CTL_WAKE  = 1;
    localparam int unsigned CTL_MEM   = 2;

    // Implemented bits; all others read as zero
    localparam logic [7:0] STATUS_USED  = 8'h8d;
    localparam logic [7:0] ENABLE_USED  = 8'h05;
    localparam logic [7:0] CONTROL_USED = 8'h06;
    localparam logic [7:0] RESET_BYTE   = 8'h00;

    // Synchroniser reset levels
    localparam logic [1:0] PIN_RESET = 2'h3;

    // Supply state
    typedef enum logic [1:0] {
        PWR_ON,
        PWR_OFF_SLEEP,
        PWR_OFF_OTHER
    } power_state_t;

    // One register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    // Whole state of the main block
    typedef struct packed {
        power_state_t      power;
        logic [7:0]        status;
        logic [7:0]        enable;
        logic [7:0]        mask;
        logic [7:0]        control;
        logic              btn_prev;
        logic              vtr_prev;
        logic [DATA_W-1:0] rdata;
        logic              irq;
        logic              pme_n;
        logic              supply_oe_n;
        logic              supply_level;
    } spm_state_t;
endpackage
`default_nettype wire

// ==== sync2.sv ====
/*
 * Two flip-flop synchroniser for a group of asynchronous levels.
 * Assumes the inputs change slowly against the clock.
 */
`default_nettype none
module sync2 #(
    parameter int unsigned     WIDTH     = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st.first  = i_async;
        next_st.second = st.first;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st <= {RESET_VAL, RESET_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.second;
endmodule
`default_nettype wire

// ==== hold_timer.sv ====
/*
 * Button hold timer: counts clock cycles while the button is held and
 * pulses once when the hold reaches HOLD_CYCLES. Release restarts it.
 * Assumes i_held is already synchronous to i_clk.
 */
`default_nettype none
module hold_timer #(
    parameter int unsigned HOLD_CYCLES = 160_000_001
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_held,
    output logic      o_fire
);
    localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYCLES - 1);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             fired;
        logic             fire;
    } timer_state_t;

    timer_state_t st;
    timer_state_t next_st;

    // Count while held, fire once, restart on release
    always_comb begin
        next_st      = st;
        next_st.fire = 1'b0;
        if (!i_held) begin
            next_st.count = '0;
            next_st.fired = 1'b0;
        end else if (!st.fired) begin
            if (st.count == LAST) begin
                next_st.fire  = 1'b1;
                next_st.fired = 1'b1;
            end else begin
                next_st.count = st.count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_fire = st.fire;
endmodule
`default_nettype wire

// ==== soft_power_event_status.sv ====
/*
 * Soft power event status: button, override, alarm and wake flags,
 * power management event and supply enable control, register port and
 * interrupt. Assumes i_rtc_alarm and i_vtr_por are one-cycle pulses on
 * i_clk; the button and standby power sense are asynchronous pins.
 */
`default_nettype none
module soft_power_event_status
    import spm_pkg::*;
#(
    parameter int unsigned HOLD_CYC = HOLD_CYCLES
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire reg_req_t          i_req,
    input  wire logic              i_power_button_in_n,
    input  wire logic              i_vtr_present,
    input  wire logic              i_rtc_alarm,
    input  wire logic              i_vtr_por,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_irq,
    output logic                   o_pm_event_out_n,
    output logic                   o_supply_enable_out,
    output logic                   o_supply_enable_oe_n
);
    spm_state_t st;
    spm_state_t next_st;
    logic [1:0] pins_sync;
    logic       btn_pressed;
    logic       vtr_ok;
    logic       hold_fire;
    logic       btn_rise;
    logic       vtr_rise;
    logic       vtr_fall;
    logic       wr_status;
    logic       sleep_req;
    logic       alarm_seen;
    logic       supply_off;
    logic       button_wake;
    logic       alarm_wake;
    logic [7:0] clr;
    logic [7:0] set;

    // Pin synchronisers: button level and standby power sense
    sync2 #(
        .WIDTH     (2),
        .RESET_VAL (PIN_RESET)
    ) u_pins (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async ({i_power_button_in_n, i_vtr_present}),
        .o_sync  (pins_sync)
    );

    assign btn_pressed = ~pins_sync[1];
    assign vtr_ok      = pins_sync[0];

    // Four second hold detector
    hold_timer #(
        .HOLD_CYCLES (HOLD_CYC)
    ) u_hold (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_held  (btn_pressed),
        .o_fire  (hold_fire)
    );

    // Event decode
    always_comb begin
        btn_rise    = btn_pressed & ~st.btn_prev;
        vtr_rise    = vtr_ok & ~st.vtr_prev;
        vtr_fall    = ~vtr_ok & st.vtr_prev;
        wr_status   = i_req.wr && (i_req.addr == STATUS_ADDR);
        sleep_req   = i_req.wr && (i_req.addr == CONTROL_ADDR) && i_req.wdata[CTL_SLEEP];
        alarm_seen  = i_rtc_alarm && (vtr_ok || st.control[CTL_MEM]);
        supply_off  = (st.power != PWR_ON);
        // A press wakes regardless of enables or override
        button_wake = supply_off && vtr_ok && btn_rise;
        // Standby return wakes on a remembered alarm with no enable needed
        alarm_wake  = supply_off && vtr_ok && !st.status[BIT_OVERRIDE]
                      && ((alarm_seen && st.enable[BIT_ALARM])
                          || (vtr_rise && st.status[BIT_ALARM]));
        // Write-one clears only touch implemented flag bits
        clr = wr_status ? (i_req.wdata & STATUS_USED) : RESET_BYTE;
        set                = RESET_BYTE;
        set[BIT_BUTTON]    = btn_rise;
        set[BIT_ALARM]     = alarm_seen;
        set[BIT_OVERRIDE]  = hold_fire;
        set[BIT_WAKE]      = (button_wake || alarm_wake)
                             && (st.power == PWR_OFF_SLEEP)
                             && st.control[CTL_WAKE];
    end

    // Next state of flags, registers, supply and outputs
    always_comb begin
        next_st          = st;
        next_st.btn_prev = btn_pressed;
        next_st.vtr_prev = vtr_ok;

        // Set wins over same-cycle write-one clear
        next_st.status = (st.status & ~clr) | set;
        if (i_vtr_por) begin
            next_st.status[BIT_WAKE] = 1'b0;
        end
        if (hold_fire) begin
            next_st.status[BIT_BUTTON] = 1'b0;
        end

        // Software writable registers
        // Control bit 0 is a command and is never stored
        if (i_req.wr) begin
            case (i_req.addr)
                ENABLE_ADDR:  next_st.enable  = i_req.wdata & ENABLE_USED;
                MASK_ADDR:    next_st.mask    = i_req.wdata & STATUS_USED;
                CONTROL_ADDR: next_st.control = i_req.wdata & CONTROL_USED;
                default:      next_st.control = st.control;
            endcase
        end

        // Supply state
        // Off states leave only through a wake; standby loss marks the off as other
        case (st.power)
            PWR_ON: begin
                if (hold_fire || vtr_fall) begin
                    next_st.power = PWR_OFF_OTHER;
                end else if (sleep_req) begin
                    next_st.power = PWR_OFF_SLEEP;
                end
            end
            PWR_OFF_SLEEP, PWR_OFF_OTHER: begin
                if (vtr_fall) begin
                    next_st.power = PWR_OFF_OTHER;
                end else if (button_wake || alarm_wake) begin
                    next_st.power = PWR_ON;
                end
            end
            default: next_st.power = PWR_ON;
        endcase

        // Read data, one cycle after the strobe
        // Unmapped addresses read as zero
        next_st.rdata = RESET_BYTE;
        if (i_req.rd) begin
            case (i_req.addr)
                STATUS_ADDR:  next_st.rdata = st.status;
                ENABLE_ADDR:  next_st.rdata = st.enable;
                MASK_ADDR:    next_st.rdata = st.mask;
                CONTROL_ADDR: next_st.rdata = st.control;
                default:      next_st.rdata = RESET_BYTE;
            endcase
        end

        // Event output, interrupt and supply pin
        next_st.pme_n = ~((st.status[BIT_BUTTON] & st.enable[BIT_BUTTON])
                          | (st.status[BIT_ALARM] & st.enable[BIT_ALARM]));
        next_st.irq          = |(st.status & st.mask);
        next_st.supply_oe_n  = (next_st.power != PWR_ON);
        next_st.supply_level = 1'b0;
    end

    // State register
    // Edge history resets to idle pin levels, so no false edge follows reset
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st             <= '0;
            st.power       <= PWR_ON;
            st.btn_prev    <= 1'b0;
            st.vtr_prev    <= 1'b1;
            st.pme_n       <= 1'b1;
            st.supply_oe_n <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata              = st.rdata;
    assign o_irq                = st.irq;
    assign o_pm_event_out_n     = st.pme_n;
    assign o_supply_enable_out  = st.supply_level;
    assign o_supply_enable_oe_n = st.supply_oe_n;

    // Checks on the flag and supply behaviour
    // All checks pause while reset is high
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    a_override_entry: assert property (
        hold_fire |=> st.status[BIT_OVERRIDE] && !st.status[BIT_BUTTON]
                      && o_supply_enable_oe_n)
        else $error("override did not force soft off");

    a_alarm_sets: assert property (
        (i_rtc_alarm && vtr_ok) |=> st.status[BIT_ALARM])
        else $error("alarm flag not set by alarm");

    a_alarm_event: assert property (
        (st.status[BIT_ALARM] && st.enable[BIT_ALARM]) |=> !o_pm_event_out_n)
        else $error("enabled alarm flag gave no event");

    a_alarm_memory: assert property (
        (i_rtc_alarm && !vtr_ok && st.control[CTL_MEM]) |=> st.status[BIT_ALARM])
        else $error("alarm lost while standby absent");

    a_vtr_return: assert property (
        (vtr_rise && supply_off && st.status[BIT_ALARM] && !st.status[BIT_OVERRIDE])
        |=> !o_supply_enable_oe_n)
        else $error("no wakeup on standby return");

    a_zero_keeps: assert property (
        (wr_status && !i_req.wdata[BIT_ALARM] && st.status[BIT_ALARM])
        |=> st.status[BIT_ALARM])
        else $error("writing zero cleared alarm flag");

    a_override_block: assert property (
        (supply_off && st.status[BIT_OVERRIDE] && !btn_rise && !vtr_fall)
        |=> st.power == $past(st.power))
        else $error("wake passed override block");

    a_wake_gate: assert property (
        (!st.control[CTL_WAKE] && !st.status[BIT_WAKE]) |=> !st.status[BIT_WAKE])
        else $error("wake flag set without wake control");

    a_wake_sleep: assert property (
        (st.power == PWR_OFF_SLEEP && st.control[CTL_WAKE] && button_wake)
        |=> st.status[BIT_WAKE] ##1 !o_supply_enable_oe_n)
        else $error("sleep wake did not set wake flag");

    a_wake_clear: assert property (
        i_vtr_por |=> !st.status[BIT_WAKE])
        else $error("wake flag survived standby reset");

    a_set_wins: assert property (
        (alarm_seen && wr_status && i_req.wdata[BIT_ALARM]) |=> st.status[BIT_ALARM])
        else $error("set lost against clear");

    // Hold pulse needs an unbroken hold
    a_hold_restart: assert property (
        !btn_pressed |=> !hold_fire)
        else $error("hold pulse without a held button");

    // Button flag and the event output
    a_button_press: assert property (
        btn_rise |=> st.status[BIT_BUTTON])
        else $error("press edge did not set button flag");

    a_button_event: assert property (
        (st.status[BIT_BUTTON] && st.enable[BIT_BUTTON]) |=> !o_pm_event_out_n)
        else $error("enabled button flag gave no event");

    a_event_idle: assert property (
        (!(st.status[BIT_BUTTON] && st.enable[BIT_BUTTON])
         && !(st.status[BIT_ALARM] && st.enable[BIT_ALARM])) |=> o_pm_event_out_n)
        else $error("event output raised with no enabled flag");

    // Only hardware sets the alarm and override flags
    a_alarm_hw_only: assert property (
        (!alarm_seen && !st.status[BIT_ALARM]) |=> !st.status[BIT_ALARM])
        else $error("alarm flag set without an alarm");

    a_memory_off: assert property (
        (i_rtc_alarm && !vtr_ok && !st.control[CTL_MEM] && !st.status[BIT_ALARM])
        |=> !st.status[BIT_ALARM])
        else $error("alarm kept without alarm memory");

    a_override_hw_only: assert property (
        (!hold_fire && !st.status[BIT_OVERRIDE]) |=> !st.status[BIT_OVERRIDE])
        else $error("override flag set without a long hold");

    a_override_keeps: assert property (
        (wr_status && !i_req.wdata[BIT_OVERRIDE] && st.status[BIT_OVERRIDE])
        |=> st.status[BIT_OVERRIDE])
        else $error("writing zero cleared override flag");

    // Wake sources and the override block
    a_alarm_wake: assert property (
        (alarm_seen && st.enable[BIT_ALARM] && supply_off && vtr_ok
         && !st.status[BIT_OVERRIDE]) |=> !o_supply_enable_oe_n)
        else $error("enabled alarm did not wake supply");

    a_alarm_block: assert property (
        (alarm_seen && st.status[BIT_OVERRIDE] && supply_off && !btn_rise)
        |=> o_supply_enable_oe_n)
        else $error("alarm woke supply through override");

    a_button_wake: assert property (
        button_wake |=> !o_supply_enable_oe_n)
        else $error("button press did not wake supply");

    // Supply release causes and the wake flag
    a_sleep_off: assert property (
        (!supply_off && sleep_req && !hold_fire && !vtr_fall)
        |=> o_supply_enable_oe_n && st.power == PWR_OFF_SLEEP)
        else $error("sleep request did not release supply");

    a_vtr_loss: assert property (
        vtr_fall |=> st.power == PWR_OFF_OTHER)
        else $error("standby loss not marked as other off");

    a_other_off: assert property (
        (st.power == PWR_OFF_OTHER && !st.status[BIT_WAKE]) |=> !st.status[BIT_WAKE])
        else $error("wake flag set after other off");

    // Register port and interrupt
    a_read_status: assert property (
        (i_req.rd && i_req.addr == STATUS_ADDR) |=> o_rdata == $past(st.status))
        else $error("status read returned wrong data");

    a_read_idle: assert property (
        !i_req.rd |=> o_rdata == RESET_BYTE)
        else $error("read data stood without a read");

    a_irq_level: assert property (
        (|(st.status & st.mask)) |=> o_irq)
        else $error("unmasked flag gave no interrupt");

    // Main scenarios
    c_override: cover property (hold_fire ##1 st.status[BIT_OVERRIDE]);
    c_alarm_wake: cover property (alarm_wake ##1 st.power == PWR_ON);
    c_sleep_wake: cover property (sleep_req ##[1:1000] st.status[BIT_WAKE]);
    c_remembered: cover property (vtr_rise && st.status[BIT_ALARM] && supply_off);
    c_button_wake: cover property (button_wake ##1 !o_supply_enable_oe_n);
endmodule
`default_nettype wire

// ==== button_supply_model.sv ====
/*
 * Far-side model: front-panel power button and switched power supply.
 * Assumes the bench asks for presses on i_press; the supply line is
 * open drain with a pull-up, and a low line switches the supply on.
 */
`default_nettype none
module button_supply_model (
    input  wire logic i_press,
    input  wire logic i_supply_data,
    input  wire logic i_supply_oe_n,
    output logic      o_button_n,
    output logic      o_supply_on
);
    timeunit 1ns;
    timeprecision 100ps;
    logic supply_line;

    // Button pin is pulled up and shorted low while pressed
    assign o_button_n = ~i_press;
    // Released line floats to the pull-up, so the supply stays off
    assign supply_line = i_supply_oe_n ? 1'b1 : i_supply_data;
    assign o_supply_on = ~supply_line;
endmodule
`default_nettype wire

// ==== soft_power_event_status_tb.sv ====
/*
 * Self-checking bench for the soft power event status block.
 * Assumes a 40 MHz clock, a shortened hold count of 20 cycles and the
 * button and supply model on the far side.
 */
`default_nettype none
module soft_power_event_status_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import spm_pkg::*;
    logic              i_clk = 0;
    logic              i_reset = 1;
    reg_req_t          req = '0;
    logic              press = 0, vtr = 1, alarm = 0, por = 0;
    logic              button_n, supply_on, irq, pm_n, sup_out, sup_oe_n;
    logic [DATA_W-1:0] rdata;
    int                fail_count = 0, num_checks = 0, cycles = 0;

    // Clock, reset and hang guard
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    soft_power_event_status #(.HOLD_CYC(20)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_req(req),
        .i_power_button_in_n(button_n), .i_vtr_present(vtr),
        .i_rtc_alarm(alarm), .i_vtr_por(por), .o_rdata(rdata), .o_irq(irq),
        .o_pm_event_out_n(pm_n), .o_supply_enable_out(sup_out),
        .o_supply_enable_oe_n(sup_oe_n));

    button_supply_model partner (
        .i_press(press), .i_supply_data(sup_out), .i_supply_oe_n(sup_oe_n),
        .o_button_n(button_n), .o_supply_on(supply_on));

    // Comparisons and bus cycles
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_clk) req.rd <= 1'b0;
        #1 check8(rdata, exp);
    endtask
    task automatic settle();
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    task automatic pulse_alarm();
        @(posedge i_clk) alarm <= 1'b1;
        @(posedge i_clk) alarm <= 1'b0;
        settle();
    endtask
    task automatic hold_button(input int n);
        @(posedge i_clk) press <= 1'b1;
        repeat (n) @(posedge i_clk);
        press <= 1'b0;
        settle();
    endtask

    // Reset values, unused bits and an unmapped place
    task automatic t_reset();
        rd(STATUS_ADDR, 8'h00);
        rd(ENABLE_ADDR, 8'h00);
        rd(MASK_ADDR, 8'h00);
        rd(CONTROL_ADDR, 8'h00);
        rd(8'h00, 8'h00);
        check1(supply_on, 1'b1);
        check1(pm_n, 1'b1);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
        wr(ENABLE_ADDR, 8'hff);
        rd(ENABLE_ADDR, ENABLE_USED);
        wr(ENABLE_ADDR, 8'h00);
    endtask

    // Alarm flag: set, write-zero, mask, same-cycle clear, clear
    task automatic t_alarm();
        pulse_alarm();
        rd(STATUS_ADDR, 8'h04);
        check1(pm_n, 1'b1);
        wr(STATUS_ADDR, 8'h00);
        rd(STATUS_ADDR, 8'h04);
        wr(MASK_ADDR, 8'h04);
        settle();
        check1(irq, 1'b1);
        @(posedge i_clk) begin
            req <= '{STATUS_ADDR, 8'h04, 1'b1, 1'b0};
            alarm <= 1'b1;
        end
        @(posedge i_clk) begin
            req.wr <= 1'b0;
            alarm <= 1'b0;
        end
        rd(STATUS_ADDR, 8'h04);
        wr(STATUS_ADDR, 8'h04);
        settle();
        check1(irq, 1'b0);
        rd(STATUS_ADDR, 8'h00);
    endtask

    // Sleep request, enabled alarm wakes, wake flag clears
    task automatic t_sleep_alarm();
        wr(ENABLE_ADDR, 8'h04);
        wr(CONTROL_ADDR, 8'h03);
        settle();
        check1(supply_on, 1'b0);
        pulse_alarm();
        check1(supply_on, 1'b1);
        check1(pm_n, 1'b0);
        rd(STATUS_ADDR, 8'h84);
        @(posedge i_clk) por <= 1'b1;
        @(posedge i_clk) por <= 1'b0;
        rd(STATUS_ADDR, 8'h04);
        rd(CONTROL_ADDR, 8'h02);
        wr(STATUS_ADDR, 8'hff);
        wr(CONTROL_ADDR, 8'h03);
        settle();
        check1(supply_on, 1'b0);
        hold_button(5);
        check1(supply_on, 1'b1);
        rd(STATUS_ADDR, 8'h81);
        wr(STATUS_ADDR, 8'hff);
    endtask

    // Sleep without wake control: button wakes, wake flag stays clear
    task automatic t_no_wake_ctl();
        wr(CONTROL_ADDR, 8'h01);
        settle();
        check1(supply_on, 1'b0);
        hold_button(5);
        check1(supply_on, 1'b1);
        rd(STATUS_ADDR, 8'h01);
        wr(STATUS_ADDR, 8'hff);
    endtask

    // Short holds restart, long hold overrides, only button wakes
    task automatic t_override();
        wr(ENABLE_ADDR, 8'h05);
        hold_button(15);
        hold_button(15);
        rd(STATUS_ADDR, 8'h01);
        check1(pm_n, 1'b0);
        wr(STATUS_ADDR, 8'hff);
        hold_button(40);
        check1(supply_on, 1'b0);
        rd(STATUS_ADDR, 8'h08);
        pulse_alarm();
        check1(supply_on, 1'b0);
        wr(STATUS_ADDR, 8'h00);
        rd(STATUS_ADDR, 8'h0c);
        hold_button(5);
        check1(supply_on, 1'b1);
        rd(STATUS_ADDR, 8'h0d);
        wr(STATUS_ADDR, 8'h0c);
        rd(STATUS_ADDR, 8'h01);
        wr(STATUS_ADDR, 8'hff);
    endtask

    // Alarm remembered while standby power is absent
    task automatic t_remember();
        wr(CONTROL_ADDR, 8'h06);
        @(posedge i_clk) vtr <= 1'b0;
        settle();
        check1(supply_on, 1'b0);
        pulse_alarm();
        rd(STATUS_ADDR, 8'h04);
        @(posedge i_clk) vtr <= 1'b1;
        settle();
        check1(supply_on, 1'b1);
        rd(STATUS_ADDR, 8'h04);
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_alarm();
        t_sleep_alarm();
        t_no_wake_ctl();
        t_override();
        t_remember();
        wrap_up();
    end
endmodule
`default_nettype wire
